// [core/rsf_pkg.sv]
// constants and types shared by the raw socket receive filter
package rsf_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_MODE2 = 8'h04;
   localparam logic [7:0] OFS_PROTO = 8'h08;
   localparam logic [7:0] OFS_CMD = 8'h0c;
   localparam logic [7:0] OFS_STATE = 8'h10;
   localparam logic [7:0] OFS_EVENT = 8'h14;
   localparam logic [7:0] OFS_NET = 8'h18;
   localparam logic [7:0] OFS_ICMP6 = 8'h1c;
   localparam logic [7:0] OFS_OWN_LO = 8'h20;
   localparam logic [7:0] OFS_OWN_HI = 8'h24;
   localparam logic [7:0] OFS_DST_LO = 8'h28;
   localparam logic [7:0] OFS_DST_HI = 8'h2c;
   // field positions
   localparam int MB_UNI = 4;
   localparam int MB_BRD = 5;
   localparam int MB_SMB = 6;
   localparam int MB_MUL = 7;
   localparam int M2_DEST_HW_MANUAL = 0;
   localparam int M2_FORCE_RESOLVE = 1;
   localparam int NB_UNR4 = 0;
   localparam int NB_UNR6 = 1;
   localparam int EV_RECV = 0;
   localparam int EV_TOUT = 1;
   // mode codes in the low nibble of socket_mode_reg
   localparam logic [3:0] MODE_UDP = 4'h2;
   localparam logic [3:0] MODE_UDP6 = 4'ha;
   localparam logic [3:0] MODE_DUAL_STACK_UDP_MODE = 4'he;
   localparam logic [3:0] MODE_RAW4 = 4'h3;
   localparam logic [3:0] MODE_RAW6 = 4'h9;
   localparam logic [3:0] MODE_MAC = 4'h7;
   // commands and socket states
   localparam logic [7:0] CMD_OPEN = 8'h01;
   localparam logic [7:0] CMD_CLOSE = 8'h10;
   localparam logic [7:0] CMD_SEND = 8'h20;
   localparam logic [7:0] ST_CLOSED = 8'h00;
   localparam logic [7:0] ST_UDP = 8'h22;
   localparam logic [7:0] ST_RAW = 8'h32;
   localparam logic [7:0] ST_MAC = 8'h42;
   // protocol numbers
   localparam logic [7:0] PROTO_TCP = 8'h06;
   localparam logic [7:0] PROTO_UDP = 8'h11;
   localparam logic [7:0] PROTO_ICMP6 = 8'h3a;
   // info header sizes and frame minimum, in bytes
   localparam logic [4:0] HDR_RAW4 = 5'd6;
   localparam logic [4:0] HDR_RAW6 = 5'd18;
   localparam logic [4:0] HDR_MAC = 5'd2;
   localparam logic [10:0] MAC_MIN_FRAME = 11'd60;
   typedef enum logic [1:0] {
      CAST_UNI = 2'b00,
      CAST_BRD = 2'b01,
      CAST_MUL = 2'b10,
      CAST_SOL = 2'b11
   } rsf_cast_t;
   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_RES = 3'b010,
      TX_SEND = 3'b100
   } rsf_tx_t;
endpackage

// [core/rsf_raw_socket_rx_filter.sv]
// socket receive filter, raw framing and send control with apb registers
`timescale 1ns/1ps
`default_nettype none
module rsf_raw_socket_rx_filter #(
   parameter int SOCK_ID = 0,
   parameter int FREE_W = 16
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_valid,
   input wire logic rx_is_udp,
   input wire logic rx_is_v6,
   input wire rsf_pkg::rsf_cast_t rx_cast,
   input wire logic rx_port_open,
   input wire logic rx_for_me,
   input wire logic [7:0] rx_proto,
   input wire logic [47:0] rx_dst_mac,
   input wire logic rx_all_node,
   input wire logic rx_gua,
   input wire logic rx_lla,
   input wire logic [3:0] rx_icmp6_sel,
   input wire logic [10:0] rx_len,
   input wire logic [FREE_W-1:0] rx_free,
   output logic rx_store,
   output logic [4:0] rx_hdr_len,
   output logic [7:0] rx_hdr_b0,
   output logic [7:0] rx_hdr_b1,
   output logic unreach_send,
   output logic [3:0] icmp6_reply_hold,
   input wire logic [10:0] tx_len,
   input wire logic tx_dst_changed,
   input wire logic res_done,
   input wire logic res_timeout,
   input wire logic [47:0] res_mac,
   output logic res_start,
   output logic tx_go,
   output logic [10:0] tx_frame_len,
   output logic [47:0] tx_dst_mac
);
   import rsf_pkg::*;

   if (FREE_W < 12) begin : g_chk
      $error("rx_free too narrow for a full frame");
   end

   logic [7:0] mode_q, mode2_q, proto_q, cmd_q, state_q, net_q, icmp6_q;
   logic [7:0] act_mode_q, act_proto_q;
   logic [1:0] ev_q;
   logic [47:0] own_q, dst_q;
   logic pready_q, resolved_q;
   rsf_tx_t tx_q;

   // apb decode; one wait state so read data comes from a flop
   logic acc, wr_en, rd_en, mapped;
   assign acc = psel & penable;
   assign wr_en = acc & pready_q & pwrite;
   assign rd_en = acc & ~pready_q & ~pwrite;
   assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_DST_HI);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= acc & ~pready_q;
      end
   end
   assign pready = pready_q;

   // read mux and error answer, latched in the wait cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pslverr <= acc & ~pready_q & ~mapped;
         if (rd_en) begin
            unique case (paddr)
               OFS_MODE: prdata <= {24'h000000, mode_q};
               OFS_MODE2: prdata <= {24'h000000, mode2_q};
               OFS_PROTO: prdata <= {24'h000000, proto_q};
               OFS_CMD: prdata <= {24'h000000, cmd_q};
               OFS_STATE: prdata <= {24'h000000, state_q};
               OFS_EVENT: prdata <= {30'h00000000, ev_q};
               OFS_NET: prdata <= {24'h000000, net_q};
               OFS_ICMP6: prdata <= {28'h0000000, icmp6_q[3:0]};
               OFS_OWN_LO: prdata <= own_q[31:0];
               OFS_OWN_HI: prdata <= {16'h0000, own_q[47:32]};
               OFS_DST_LO: prdata <= dst_q[31:0];
               OFS_DST_HI: prdata <= {16'h0000, dst_q[47:32]};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // plain configuration registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mode_q <= 8'h00;
         mode2_q <= 8'h00;
         proto_q <= 8'h00;
         net_q <= 8'h00;
         icmp6_q <= 8'h00;
         own_q <= 48'h0000_0000_0000;
         dst_q <= 48'h0000_0000_0000;
      end else if (wr_en) begin
         unique case (paddr)
            OFS_MODE: mode_q <= pwdata[7:0];
            OFS_MODE2: mode2_q <= pwdata[7:0];
            OFS_PROTO: proto_q <= pwdata[7:0];
            OFS_NET: net_q <= pwdata[7:0];
            OFS_ICMP6: icmp6_q <= {4'h0, pwdata[3:0]};
            OFS_OWN_LO: own_q[31:0] <= pwdata;
            OFS_OWN_HI: own_q[47:32] <= pwdata[15:0];
            OFS_DST_LO: dst_q[31:0] <= pwdata;
            OFS_DST_HI: dst_q[47:32] <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // open is legal only for known modes and allowed protocol / socket
   logic [3:0] nib;
   logic raw_req, open_ok;
   assign nib = mode_q[3:0];
   assign raw_req = (nib == MODE_RAW4) || (nib == MODE_RAW6);
   always_comb begin
      open_ok = 1'b0;
      if (nib == MODE_UDP || nib == MODE_UDP6 || nib == MODE_DUAL_STACK_UDP_MODE) begin
         open_ok = 1'b1;
      end else if (raw_req) begin
         open_ok = (proto_q != PROTO_TCP) && (proto_q != PROTO_UDP);
      end else if (nib == MODE_MAC) begin
         open_ok = (SOCK_ID == 0);
      end
   end

   // command register: host writes, hardware clears it the next cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cmd_q <= 8'h00;
      end else if (wr_en && paddr == OFS_CMD) begin
         cmd_q <= pwdata[7:0];
      end else begin
         cmd_q <= 8'h00;
      end
   end

   // socket state and the mode latched at open
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_CLOSED;
         act_mode_q <= 8'h00;
         act_proto_q <= 8'h00;
      end else if (cmd_q == CMD_CLOSE) begin
         state_q <= ST_CLOSED;
      end else if (cmd_q == CMD_OPEN && state_q == ST_CLOSED && open_ok) begin
         act_mode_q <= mode_q;
         act_proto_q <= proto_q;
         state_q <= raw_req ? ST_RAW : (nib == MODE_MAC ? ST_MAC : ST_UDP);
      end
   end

   // receive filter
   logic [3:0] am;
   logic udp_m, v6_udp, is_mul, keep, fits, unr_d;
   logic [4:0] hlen_d;
   logic [7:0] b0_d;
   logic [FREE_W-1:0] need;
   assign am = act_mode_q[3:0];
   assign udp_m = (state_q == ST_UDP);
   assign v6_udp = udp_m && (am == MODE_UDP6 || am == MODE_DUAL_STACK_UDP_MODE);
   assign is_mul = (rx_cast == CAST_MUL) || (rx_cast == CAST_SOL);
   always_comb begin
      keep = 1'b0;
      hlen_d = 5'd0;
      b0_d = {5'b00000, rx_len[10:8]};
      if (udp_m && rx_is_udp && rx_for_me) begin
         unique case (rx_cast)
            CAST_UNI: keep = ~act_mode_q[MB_MUL] | ~act_mode_q[MB_UNI];
            CAST_BRD: keep = ~act_mode_q[MB_BRD];
            CAST_MUL: keep = act_mode_q[MB_MUL];
            CAST_SOL: keep = act_mode_q[MB_MUL] & ~(v6_udp & act_mode_q[MB_SMB]);
         endcase
      end else if (state_q == ST_RAW && !rx_is_udp && rx_proto == act_proto_q) begin
         if (am == MODE_RAW4 && !rx_is_v6) begin
            keep = 1'b1;
            hlen_d = HDR_RAW4;
         end else if (am == MODE_RAW6 && rx_is_v6) begin
            keep = !(act_proto_q == PROTO_ICMP6 && |(rx_icmp6_sel & icmp6_q[3:0]));
            hlen_d = HDR_RAW6;
            b0_d = {1'b1, rx_all_node, is_mul, rx_gua, rx_lla, rx_len[10:8]};
         end
      end else if (state_q == ST_MAC) begin
         keep = ~act_mode_q[MB_MUL] | (rx_cast != CAST_UNI) | (rx_dst_mac == own_q);
         hlen_d = HDR_MAC;
      end
   end
   assign need = FREE_W'(rx_len) + FREE_W'(hlen_d);
   assign fits = (need <= rx_free);
   // unreachable replies come from socket zero's copy only
   assign unr_d = (SOCK_ID == 0) && rx_valid && rx_is_udp && !rx_port_open
                  && !(rx_is_v6 ? net_q[NB_UNR6] : net_q[NB_UNR4]);

   // registered receive outputs
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rx_store <= 1'b0;
         rx_hdr_len <= 5'd0;
         rx_hdr_b0 <= 8'h00;
         rx_hdr_b1 <= 8'h00;
         unreach_send <= 1'b0;
         icmp6_reply_hold <= 4'h0;
      end else begin
         rx_store <= rx_valid & keep & fits;
         rx_hdr_len <= hlen_d;
         rx_hdr_b0 <= b0_d;
         rx_hdr_b1 <= rx_len[7:0];
         unreach_send <= unr_d;
         icmp6_reply_hold <= (state_q == ST_RAW && am == MODE_RAW6 && act_proto_q == PROTO_ICMP6)
                             ? icmp6_q[3:0] : 4'h0;
      end
   end

   // event flags: hardware set wins over a write-one clear
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ev_q <= 2'b00;
      end else begin
         ev_q[EV_RECV] <= (rx_valid & keep & fits)
                          | (ev_q[EV_RECV] & ~(wr_en && paddr == OFS_EVENT && pwdata[EV_RECV]));
         ev_q[EV_TOUT] <= (tx_q == TX_RES && !res_done && res_timeout)
                          | (ev_q[EV_TOUT] & ~(wr_en && paddr == OFS_EVENT && pwdata[EV_TOUT]));
      end
   end

   // send sequencer; a send while busy is cleared and ignored
   logic send_cmd, need_res;
   assign send_cmd = (cmd_q == CMD_SEND) && (state_q == ST_RAW || state_q == ST_MAC);
   assign need_res = (state_q == ST_RAW) && !mode2_q[M2_DEST_HW_MANUAL]
                     && (mode2_q[M2_FORCE_RESOLVE] || !resolved_q || tx_dst_changed);
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tx_q <= TX_IDLE;
         resolved_q <= 1'b0;
         res_start <= 1'b0;
      end else begin
         res_start <= 1'b0;
         if (cmd_q == CMD_OPEN) begin
            resolved_q <= 1'b0;
         end
         unique case (tx_q)
            TX_IDLE: begin
               if (send_cmd && need_res) begin
                  res_start <= 1'b1;
                  tx_q <= TX_RES;
               end else if (send_cmd) begin
                  tx_q <= TX_SEND;
               end
            end
            TX_RES: begin
               if (res_done) begin
                  resolved_q <= 1'b1;
                  tx_q <= TX_SEND;
               end else if (res_timeout) begin
                  tx_q <= TX_IDLE;
               end
            end
            TX_SEND: tx_q <= TX_IDLE;
         endcase
      end
   end

   // resolver address only stands with res_done, so later sends use this copy
   logic [47:0] learned_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         learned_q <= 48'h0000_0000_0000;
      end else if (tx_q == TX_RES && res_done) begin
         learned_q <= res_mac;
      end
   end

   // frame launch; the mac address is fixed when the frame goes
   logic [47:0] mac_sel;
   assign mac_sel = mode2_q[M2_DEST_HW_MANUAL] ? dst_q : learned_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tx_go <= 1'b0;
         tx_frame_len <= 11'd0;
         tx_dst_mac <= 48'h0000_0000_0000;
      end else begin
         tx_go <= (tx_q == TX_SEND);
         if (tx_q == TX_SEND) begin
            tx_dst_mac <= mac_sel;
            tx_frame_len <= (state_q == ST_MAC && tx_len < MAC_MIN_FRAME) ? MAC_MIN_FRAME : tx_len;
         end
      end
   end

   cmd_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
      cmd_q != 8'h00 && !(wr_en && paddr == OFS_CMD) |=> cmd_q == 8'h00)
      else $error("command not cleared");
   mac_socket_a: assert property (@(posedge sys_clk) disable iff (rst)
      SOCK_ID != 0 |-> state_q != ST_MAC)
      else $error("raw mac open on nonzero socket");
   raw_proto_a: assert property (@(posedge sys_clk) disable iff (rst)
      state_q == ST_RAW |-> act_proto_q != PROTO_TCP && act_proto_q != PROTO_UDP)
      else $error("raw socket on tcp or udp");
   udp_mcast_a: assert property (@(posedge sys_clk) disable iff (rst)
      rx_valid && udp_m && !act_mode_q[MB_MUL] && rx_cast == CAST_MUL |=> !rx_store)
      else $error("multicast stored in plain udp");
   bcast_block_a: assert property (@(posedge sys_clk) disable iff (rst)
      rx_valid && udp_m && act_mode_q[MB_BRD] && rx_cast == CAST_BRD |=> !rx_store && !$rose(ev_q[EV_RECV]))
      else $error("broadcast not blocked");
   sol_block_a: assert property (@(posedge sys_clk) disable iff (rst)
      rx_valid && v6_udp && act_mode_q[MB_SMB] && rx_cast == CAST_SOL |=> !rx_store)
      else $error("solicited multicast not blocked");
   unreach_blk_a: assert property (@(posedge sys_clk) disable iff (rst)
      rx_valid && rx_is_udp && !rx_is_v6 && net_q[NB_UNR4] |=> !unreach_send)
      else $error("unreachable not suppressed");
   fit_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
      rx_valid && !fits |=> !rx_store)
      else $error("oversize packet stored");
   res_tout_a: assert property (@(posedge sys_clk) disable iff (rst)
      tx_q == TX_RES && !res_done && res_timeout && state_q == ST_RAW && cmd_q != CMD_CLOSE
      |=> ev_q[EV_TOUT] && tx_q == TX_IDLE && state_q == ST_RAW ##1 !tx_go)
      else $error("timeout not handled");
   manual_mac_a: assert property (@(posedge sys_clk) disable iff (rst)
      tx_q == TX_IDLE && send_cmd && mode2_q[M2_DEST_HW_MANUAL] |=> !res_start ##1 tx_go && tx_dst_mac == $past(dst_q))
      else $error("manual address not used");
   pad_frame_a: assert property (@(posedge sys_clk) disable iff (rst)
      tx_go && state_q == ST_MAC |-> tx_frame_len >= MAC_MIN_FRAME)
      else $error("short mac frame not padded");
   icmp6_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
      rx_valid && state_q == ST_RAW && am == MODE_RAW6 && act_proto_q == PROTO_ICMP6
      && (rx_icmp6_sel & icmp6_q[3:0]) != 4'h0 |=> !rx_store)
      else $error("withheld icmpv6 packet stored");
   mac_filter_a: assert property (@(posedge sys_clk) disable iff (rst)
      rx_valid && state_q == ST_MAC && act_mode_q[MB_MUL] && rx_cast == CAST_UNI && rx_dst_mac != own_q
      |=> !rx_store)
      else $error("foreign unicast frame stored");
   raw4_header_a: assert property (@(posedge sys_clk) disable iff (rst)
      rx_valid && state_q == ST_RAW && am == MODE_RAW4 && !rx_is_v6 && !rx_is_udp && rx_proto == act_proto_q
      |=> rx_hdr_len == HDR_RAW4)
      else $error("raw ipv4 header size wrong");
   unreach_send_a: assert property (@(posedge sys_clk) disable iff (rst)
      SOCK_ID == 0 && rx_valid && rx_is_udp && !rx_port_open && !rx_is_v6 && !net_q[NB_UNR4] |=> unreach_send)
      else $error("port unreachable not sent");
endmodule // rsf_raw_socket_rx_filter
`default_nettype wire

// [testbench/rsf_resolver_model.sv]
// resolver stand-in that answers address requests from the socket
`timescale 1ns/1ps
`default_nettype none
module rsf_resolver_model #(
   parameter logic [47:0] MAC = 48'h02a1b2c3d4e5,
   parameter int DELAY = 5
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic res_start,
   input wire logic fail,
   output logic res_done,
   output logic res_timeout,
   output logic [47:0] res_mac
);
   int cnt;
   // one request in flight; reply or timeout after a fixed delay, as the bench asks
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         res_done <= 1'b0;
         res_timeout <= 1'b0;
      end else begin
         res_done <= 1'b0;
         res_timeout <= 1'b0;
         if (res_start) begin
            cnt <= DELAY;
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
            res_done <= (cnt == 1) && !fail;
            res_timeout <= (cnt == 1) && fail;
         end
      end
   end
   // address only meaningful with done; scrambled otherwise so stale use shows
   assign res_mac = res_done ? MAC : ~MAC;
endmodule // rsf_resolver_model
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the raw socket receive filter
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rsf_pkg::*;
   logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, er, fail;
   logic rx_valid, rx_is_udp, rx_is_v6, rx_port_open, rx_for_me, rx_all_node, rx_gua, rx_lla, rx_store;
   logic unreach_send, tx_dst_changed, res_done, res_timeout, res_start, tx_go;
   logic [7:0] paddr, rx_proto, rx_hdr_b0, rx_hdr_b1, h0, h1;
   logic [31:0] pwdata, prdata, rd;
   logic [47:0] rx_dst_mac, res_mac, tx_dst_mac, go_mac;
   logic [3:0] rx_icmp6_sel, icmp6_reply_hold;
   logic [10:0] rx_len, tx_len, tx_frame_len, go_len;
   logic [15:0] rx_free;
   logic [4:0] rx_hdr_len, hl;
   rsf_cast_t rx_cast;
   int err_count = 0;
   int checks_done = 0;
   int go_n = 0;
   int rs_n = 0;
   int to_n = 0;

   rsf_raw_socket_rx_filter #(.SOCK_ID(0), .FREE_W(16)) dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_is_udp, .rx_is_v6, .rx_cast, .rx_port_open, .rx_for_me,
      .rx_proto, .rx_dst_mac, .rx_all_node, .rx_gua, .rx_lla, .rx_icmp6_sel, .rx_len, .rx_free, .rx_store,
      .rx_hdr_len, .rx_hdr_b0, .rx_hdr_b1, .unreach_send, .icmp6_reply_hold, .tx_len, .tx_dst_changed,
      .res_done, .res_timeout, .res_mac, .res_start, .tx_go, .tx_frame_len, .tx_dst_mac);
   rsf_resolver_model model (.sys_clk, .rst, .res_start, .fail, .res_done, .res_timeout, .res_mac);

   // 20 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // send-side pulses are counted here, since they may pass while a poll is running
   always @(posedge sys_clk) begin
      if (tx_go === 1'b1) begin
         go_n++;
         go_len = tx_frame_len;
         go_mac = tx_dst_mac;
      end
      if (res_start === 1'b1) rs_n++;
      if (res_timeout === 1'b1) to_n++;
   end

   task automatic tally_and_finish;
      if (err_count == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         err_count++;
         tally_and_finish();
      end
   endtask

   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask

   // issue a command, poll until it clears, then check the socket state
   task automatic cmd(input logic [7:0] c, input logic [7:0] st);
      int n;
      apb(1'b1, OFS_CMD, {24'h0, c});
      n = 0;
      do begin
         apb(1'b0, OFS_CMD, 32'h0);
         n++;
      end while (rd !== 32'h0 && n < 10);
      if (n >= 10) begin
         err_count++;
         tally_and_finish();
      end
      rdc("state", OFS_STATE, {24'h0, st});
   endtask

   task automatic opn(input logic [7:0] m, input logic [7:0] st);
      apb(1'b1, OFS_MODE, {24'h0, m});
      cmd(CMD_OPEN, st);
   endtask

   // offer one packet and judge the one-cycle answer
   task automatic rx(input rsf_cast_t c, input logic udp, input logic v6, input logic [7:0] pr,
      input logic [47:0] dm, input logic [10:0] ln, input logic [15:0] fr, input logic es, input logic eu);
      rx_valid <= 1'b1;
      rx_cast <= c;
      rx_is_udp <= udp;
      rx_is_v6 <= v6;
      rx_proto <= pr;
      rx_dst_mac <= dm;
      rx_len <= ln;
      rx_free <= fr;
      @(posedge sys_clk);
      rx_valid <= 1'b0;
      #1;
      hl = rx_hdr_len;
      h0 = rx_hdr_b0;
      h1 = rx_hdr_b1;
      chk("rx_store", es, rx_store);
      chk("unreach_send", eu, unreach_send);
      @(posedge sys_clk);
   endtask

   // send command; waits for either a frame or a resolver timeout
   task automatic send(input logic [10:0] ln, input logic ch, input logic [7:0] st, input int done_n);
      int n;
      tx_len <= ln;
      tx_dst_changed <= ch;
      cmd(CMD_SEND, st);
      n = 0;
      while (go_n + to_n != done_n && n < 40) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 40) begin
         err_count++;
         tally_and_finish();
      end
   endtask

   task automatic udp_case;
      rx_for_me <= 1'b1;
      rx_port_open <= 1'b1;
      opn(8'h22, ST_UDP);
      rx(CAST_UNI, 1, 0, PROTO_UDP, 0, 11'd8, 16'd1000, 1, 0);
      rx(CAST_BRD, 1, 0, PROTO_UDP, 0, 11'd8, 16'd1000, 0, 0);
      rx(CAST_MUL, 1, 0, PROTO_UDP, 0, 11'd8, 16'd1000, 0, 0);
      cmd(CMD_CLOSE, ST_CLOSED);
      opn(8'h92, ST_UDP);
      rx(CAST_UNI, 1, 0, PROTO_UDP, 0, 11'd8, 16'd1000, 0, 0);
      rx(CAST_BRD, 1, 0, PROTO_UDP, 0, 11'd8, 16'd1000, 1, 0);
      rx(CAST_MUL, 1, 0, PROTO_UDP, 0, 11'd8, 16'd1000, 1, 0);
      rx_port_open <= 1'b0;
      rx_for_me <= 1'b0;
      rx(CAST_UNI, 1, 0, PROTO_UDP, 0, 11'd8, 16'd1000, 0, 1);
      apb(1'b1, OFS_NET, 32'h1);
      rx(CAST_UNI, 1, 0, PROTO_UDP, 0, 11'd8, 16'd1000, 0, 0);
      rx(CAST_UNI, 1, 1, PROTO_UDP, 0, 11'd8, 16'd1000, 0, 1);
      cmd(CMD_CLOSE, ST_CLOSED);
      rx_port_open <= 1'b1;
      rx_for_me <= 1'b1;
      opn(8'hca, ST_UDP);
      rx(CAST_SOL, 1, 1, PROTO_UDP, 0, 11'd8, 16'd1000, 0, 0);
      rx(CAST_MUL, 1, 1, PROTO_UDP, 0, 11'd8, 16'd1000, 1, 0);
      cmd(CMD_CLOSE, ST_CLOSED);
      opn(8'h8e, ST_UDP);
      rx(CAST_SOL, 1, 1, PROTO_UDP, 0, 11'd8, 16'd1000, 1, 0);
      cmd(CMD_CLOSE, ST_CLOSED);
   endtask

   task automatic raw_case;
      apb(1'b1, OFS_PROTO, {24'h0, PROTO_TCP});
      opn(8'h03, ST_CLOSED);
      apb(1'b1, OFS_PROTO, {24'h0, PROTO_UDP});
      opn(8'h03, ST_CLOSED);
      apb(1'b1, OFS_PROTO, 32'h1);
      opn(8'h03, ST_RAW);
      apb(1'b1, OFS_EVENT, 32'h3);
      rx(CAST_UNI, 0, 0, 8'h01, 0, 11'd300, 16'd200, 0, 0);
      rx(CAST_UNI, 0, 0, 8'h02, 0, 11'd300, 16'd1000, 0, 0);
      rdc("event", OFS_EVENT, 32'h0);
      rx(CAST_UNI, 0, 0, 8'h01, 0, 11'd300, 16'd1000, 1, 0);
      chk("hdr_len", HDR_RAW4, hl);
      chk("hdr_b0", 8'h01, h0);
      chk("hdr_b1", 8'h2c, h1);
      rdc("event", OFS_EVENT, 32'h1);
      fail <= 1'b0;
      send(11'd100, 1, ST_RAW, 1);
      chk("go_len", 11'd100, go_len);
      chk("go_mac", 48'h02a1b2c3d4e5, go_mac);
      send(11'd90, 0, ST_RAW, 2);
      chk("go_mac", 48'h02a1b2c3d4e5, go_mac);
      chk("res_n", 1, rs_n);
      apb(1'b1, OFS_EVENT, 32'h3);
      fail <= 1'b1;
      send(11'd80, 1, ST_RAW, 3);
      chk("go_n", 2, go_n);
      rdc("event", OFS_EVENT, 32'h2);
      rdc("state", OFS_STATE, {24'h0, ST_RAW});
      fail <= 1'b0;
      cmd(CMD_CLOSE, ST_CLOSED);
      apb(1'b1, OFS_MODE2, 32'h2);
      opn(8'h03, ST_RAW);
      send(11'd100, 1, ST_RAW, 4);
      send(11'd100, 0, ST_RAW, 5);
      chk("res_n", 4, rs_n);
      cmd(CMD_CLOSE, ST_CLOSED);
      apb(1'b1, OFS_PROTO, {24'h0, PROTO_ICMP6});
      opn(8'h09, ST_RAW);
      rx_all_node <= 1'b1;
      rx_lla <= 1'b1;
      rx(CAST_MUL, 0, 1, PROTO_ICMP6, 0, 11'h123, 16'd1000, 1, 0);
      chk("hdr_len", HDR_RAW6, hl);
      chk("hdr_b0", 8'he9, h0);
      chk("hdr_b1", 8'h23, h1);
      apb(1'b1, OFS_ICMP6, 32'h5);
      rx_icmp6_sel <= 4'h4;
      rx(CAST_MUL, 0, 1, PROTO_ICMP6, 0, 11'h123, 16'd1000, 0, 0);
      chk("icmp6_hold", 4'h5, icmp6_reply_hold);
      rx_icmp6_sel <= 4'h0;
      cmd(CMD_CLOSE, ST_CLOSED);
   endtask

   task automatic mac_case;
      apb(1'b1, OFS_MODE2, 32'h1);
      apb(1'b1, OFS_OWN_LO, 32'h22334455);
      apb(1'b1, OFS_OWN_HI, 32'h0211);
      apb(1'b1, OFS_DST_LO, 32'h0c0d0e0f);
      apb(1'b1, OFS_DST_HI, 32'h0a0b);
      opn(8'h87, ST_MAC);
      rx(CAST_UNI, 0, 0, 0, 48'h02aabbccddee, 11'd64, 16'd1000, 0, 0);
      rx(CAST_UNI, 0, 0, 0, 48'h021122334455, 11'd64, 16'd1000, 1, 0);
      chk("hdr_len", HDR_MAC, hl);
      rx(CAST_BRD, 0, 0, 0, 48'hffffffffffff, 11'd64, 16'd1000, 1, 0);
      send(11'd20, 1, ST_MAC, 6);
      chk("go_len", MAC_MIN_FRAME, go_len);
      chk("go_mac", 48'h0a0b0c0d0e0f, go_mac);
      chk("res_n", 4, rs_n);
      send(11'd100, 0, ST_MAC, 7);
      chk("go_len", 11'd100, go_len);
      cmd(CMD_CLOSE, ST_CLOSED);
      opn(8'h07, ST_MAC);
      rx(CAST_UNI, 0, 0, 0, 48'h02aabbccddee, 11'd64, 16'd1000, 1, 0);
   endtask

   // main sequence
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      {rx_valid, rx_is_udp, rx_is_v6, rx_port_open, rx_for_me, rx_all_node, rx_gua, rx_lla} = 8'h00;
      rx_cast = CAST_UNI;
      rx_proto = 8'h00;
      rx_dst_mac = 48'h0;
      rx_icmp6_sel = 4'h0;
      rx_len = 11'h0;
      rx_free = 16'h0;
      tx_len = 11'h0;
      tx_dst_changed = 1'b0;
      fail = 1'b0;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      rdc("state", OFS_STATE, 32'h0);
      apb(1'b0, 8'h30, 32'h0);
      chk("pslverr", 1'b1, er);
      chk("unmapped", 32'h0, rd);
      udp_case();
      raw_case();
      mac_case();
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
